// file: pkg/ohcimc_pkg.sv
// Purpose: Shared constants for the host-controller misc/link enhancement registers
// Assumes: Byte offsets in configuration space, 32-bit register words
// Notes: Bits outside the RW masks are read-only zero
package ohcimc_pkg;

    // Register byte offsets
    localparam logic [7:0] OHCIMC_MISC_OFS = 8'hf0;
    localparam logic [7:0] OHCIMC_LEC_OFS = 8'hf4;

    // Misc configuration field positions
    localparam int OHCIMC_PMV_BIT = 7;
    localparam int OHCIMC_NOABORT_BIT = 4;
    localparam int OHCIMC_SERIAL_BIT = 3;
    localparam int OHCIMC_LGATE_BIT = 2;
    localparam int OHCIMC_PGATE_BIT = 1;
    localparam int OHCIMC_KEEP_BIT = 0;

    // Reset values and writable bit masks
    localparam logic [31:0] OHCIMC_MISC_RST = 32'h0000_0090;
    localparam logic [31:0] OHCIMC_MISC_RW_MASK = 32'h0000_009f;
    localparam logic [31:0] OHCIMC_LEC_RST = 32'h0000_4000;
    localparam logic [31:0] OHCIMC_LEC_RW_MASK = 32'h0000_f000;

    // Power-management version codes
    localparam logic [2:0] OHCIMC_PM_VER_12 = 3'h3;
    localparam logic [2:0] OHCIMC_PM_VER_11 = 3'h2;

    // Fill byte for answers from a stopped link domain
    localparam logic [7:0] OHCIMC_LINK_FILL = 8'hff;

    // Synchroniser depth
    localparam int OHCIMC_SYNC_STAGES = 2;

    // Link-access guard states
    typedef enum logic [1:0] {
        OHCIMC_G_IDLE = 2'b01,
        OHCIMC_G_FWD = 2'b10
    } ohcimc_guard_state_t;

endpackage

// file: rtl/ohcimc_link_guard.sv
// Purpose: Answers link-core register accesses, aborting or filling when clock stopped
// Assumes: clk_active_i already synchronised; core handshake on core_clk_i
// Notes: One access at a time; request ignored while one is in flight
`timescale 1ns/1ps
`default_nettype none
module ohcimc_link_guard
    import ohcimc_pkg::*;
#(
    parameter int DATA_W = 32
)
(
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic req_i,
    input wire logic clk_active_i,
    input wire logic no_abort_i,
    input wire logic core_ack_i,
    input wire logic [DATA_W-1:0] core_rdata_i,
    output logic core_req_o,
    output logic done_o,
    output logic abort_o,
    output logic [DATA_W-1:0] rdata_o
);

    // Fill pattern needs whole bytes
    generate
        if (DATA_W < 8 || DATA_W % 8 != 0)
        begin : g_bad_width
            $error("DATA_W must be a whole number of bytes");
        end
    endgenerate

    ohcimc_guard_state_t state;
    ohcimc_guard_state_t next_state;
    logic next_core_req;
    logic next_done;
    logic next_abort;
    logic [DATA_W-1:0] next_rdata;

    always_comb
    begin
        next_state = state;
        next_core_req = 1'b0;
        next_done = 1'b0;
        next_abort = 1'b0;
        next_rdata = rdata_o;
        case (state)
            OHCIMC_G_IDLE:
            begin
                if (req_i && clk_active_i)
                begin
                    next_core_req = 1'b1;
                    next_state = OHCIMC_G_FWD;
                end
                else if (req_i)
                begin
                    next_done = 1'b1;
                    next_abort = ~no_abort_i;
                    next_rdata = no_abort_i ? {(DATA_W / 8){OHCIMC_LINK_FILL}} : '0;
                end
            end
            OHCIMC_G_FWD:
            begin
                if (core_ack_i)
                begin
                    next_done = 1'b1;
                    next_rdata = core_rdata_i;
                    next_state = OHCIMC_G_IDLE;
                end
                else if (!clk_active_i)
                begin
                    // Clock stopped mid-access
                    next_done = 1'b1;
                    next_abort = ~no_abort_i;
                    next_rdata = no_abort_i ? {(DATA_W / 8){OHCIMC_LINK_FILL}} : '0;
                    next_state = OHCIMC_G_IDLE;
                end
            end
            default:
            begin
                next_state = OHCIMC_G_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state <= OHCIMC_G_IDLE;
            core_req_o <= 1'b0;
            done_o <= 1'b0;
            abort_o <= 1'b0;
            rdata_o <= '0;
        end
        else
        begin
            state <= next_state;
            core_req_o <= next_core_req;
            done_o <= next_done;
            abort_o <= next_abort;
            rdata_o <= next_rdata;
        end
    end

endmodule
`default_nettype wire

// file: rtl/ohcimc_regs.sv
// Purpose: Misc function configuration and link enhancement control registers
// Assumes: Configuration accesses on core_clk_i; arst_n_i is the combined
//          fundamental and power-on reset
// Notes: Link clock status inputs are synchronised before use
//
// Functional notes
// - Version bit one reports version 011b
// - Version bit zero reports version 010b
// - Misc bits 6-5 always read zero
// - Bit 4 selects no-abort completion mode
// - Stopped link, bit clear: target abort
// - Stopped link, bit set: FFh data
// - Bit 3 stored, resets zero, no effect
// - Bit 2 clear: link clock auto-gated
// - Bit 2 set: link clock kept running
// - Bit 1 clear: PCI clock auto-gated
// - Bit 1 set: PCI clock kept running
// - Bit 0 stored, resets zero, no effect
// - Control bits reset on fundamental reset
// - Enhancement register at F4h, resets 00004000h
// - Enhancement bits act only when enabled
// - Enhancement loadable by software or EEPROM
`timescale 1ns/1ps
`default_nettype none
module ohcimc_regs
    import ohcimc_pkg::*;
#(
    parameter int DATA_W = 32
)
(
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic cfg_req_i,
    input wire logic cfg_we_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic cfg_ack_o,
    output logic [31:0] cfg_rdata_o,
    input wire logic eeprom_load_i,
    input wire logic [31:0] eeprom_lec_i,
    input wire logic enhancement_enable_bit_i,
    input wire logic link_clk_active_i,
    input wire logic link_clk_need_i,
    input wire logic pci_clk_need_i,
    input wire logic lk_req_i,
    input wire logic lk_core_ack_i,
    input wire logic [DATA_W-1:0] lk_core_rdata_i,
    output logic lk_core_req_o,
    output logic lk_done_o,
    output logic lk_abort_o,
    output logic [DATA_W-1:0] lk_rdata_o,
    output logic [2:0] pm_version_o,
    output logic link_clk_run_o,
    output logic pci_clk_run_o,
    output logic [31:0] lec_effective_o
);

    // Only a 32-bit link-core path is served
    generate
        if (DATA_W != 32)
        begin : g_bad_width
            $error("DATA_W must be 32 for the link-core data path");
        end
    endgenerate

    // Byte-lane merge limited to writable bits
    function automatic logic [31:0] ohcimc_merge(
        input logic [31:0] old_val,
        input logic [31:0] wdata,
        input logic [3:0] be,
        input logic [31:0] rw_mask
    );
        logic [31:0] lanes;
        lanes = '0;
        for (int i = 0; i < 4; i++)
        begin
            lanes[i*8 +: 8] = be[i] ? wdata[i*8 +: 8] : old_val[i*8 +: 8];
        end
        return lanes & rw_mask;
    endfunction

    // Two-stage synchronisers for link-domain levels
    logic [1:0] async_in;
    logic [1:0] sync_q [OHCIMC_SYNC_STAGES];
    logic [1:0] next_sync_q [OHCIMC_SYNC_STAGES];
    logic link_active_s;
    logic link_need_s;

    assign async_in = {link_clk_need_i, link_clk_active_i};

    genvar g;
    generate
        for (g = 0; g < OHCIMC_SYNC_STAGES; g++)
        begin : g_sync
            if (g == 0)
            begin : g_first
                assign next_sync_q[g] = async_in;
            end
            else
            begin : g_rest
                assign next_sync_q[g] = sync_q[g-1];
            end
            always_ff @(posedge core_clk_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                begin
                    sync_q[g] <= 2'h0;
                end
                else
                begin
                    sync_q[g] <= next_sync_q[g];
                end
            end
        end
    endgenerate

    assign link_active_s = sync_q[OHCIMC_SYNC_STAGES-1][0];
    assign link_need_s = sync_q[OHCIMC_SYNC_STAGES-1][1];

    // Register state
    logic [31:0] misc_function_config;
    logic [31:0] link_enhancement_control;
    logic [31:0] next_misc;
    logic [31:0] next_lec;
    logic next_ack;
    logic [31:0] next_rdata;
    logic misc_hit;
    logic lec_hit;
    logic cfg_write;

    assign misc_hit = (cfg_addr_i == OHCIMC_MISC_OFS);
    assign lec_hit = (cfg_addr_i == OHCIMC_LEC_OFS);
    assign cfg_write = cfg_req_i && cfg_we_i;

    always_comb
    begin
        next_misc = misc_function_config;
        next_lec = link_enhancement_control;
        next_ack = cfg_req_i;
        next_rdata = cfg_rdata_o;
        if (cfg_write && misc_hit)
        begin
            next_misc = ohcimc_merge(misc_function_config, cfg_wdata_i, cfg_be_i,
                OHCIMC_MISC_RW_MASK);
        end
        if (eeprom_load_i)
        begin
            next_lec = eeprom_lec_i & OHCIMC_LEC_RW_MASK;
        end
        else if (cfg_write && lec_hit)
        begin
            next_lec = ohcimc_merge(link_enhancement_control, cfg_wdata_i, cfg_be_i,
                OHCIMC_LEC_RW_MASK);
        end
        if (cfg_req_i && !cfg_we_i)
        begin
            if (misc_hit)
            begin
                next_rdata = misc_function_config & OHCIMC_MISC_RW_MASK;
            end
            else if (lec_hit)
            begin
                next_rdata = link_enhancement_control & OHCIMC_LEC_RW_MASK;
            end
            else
            begin
                next_rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            misc_function_config <= OHCIMC_MISC_RST;
            link_enhancement_control <= OHCIMC_LEC_RST;
            cfg_ack_o <= 1'b0;
            cfg_rdata_o <= 32'h0000_0000;
        end
        else
        begin
            misc_function_config <= next_misc;
            link_enhancement_control <= next_lec;
            cfg_ack_o <= next_ack;
            cfg_rdata_o <= next_rdata;
        end
    end

    // Control outputs derived from the registers
    logic [2:0] next_pm_version;
    logic next_link_run;
    logic next_pci_run;
    logic [31:0] next_lec_eff;

    always_comb
    begin
        next_pm_version = misc_function_config[OHCIMC_PMV_BIT] ? OHCIMC_PM_VER_12
            : OHCIMC_PM_VER_11;
        next_link_run = misc_function_config[OHCIMC_LGATE_BIT] | link_need_s;
        next_pci_run = misc_function_config[OHCIMC_PGATE_BIT] | pci_clk_need_i;
        next_lec_eff = enhancement_enable_bit_i ? link_enhancement_control : 32'h0000_0000;
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pm_version_o <= OHCIMC_PM_VER_12;
            link_clk_run_o <= 1'b0;
            pci_clk_run_o <= 1'b0;
            lec_effective_o <= 32'h0000_0000;
        end
        else
        begin
            pm_version_o <= next_pm_version;
            link_clk_run_o <= next_link_run;
            pci_clk_run_o <= next_pci_run;
            lec_effective_o <= next_lec_eff;
        end
    end

    // Link-core access answering
    ohcimc_link_guard #(
        .DATA_W(DATA_W)
    ) i_ohcimc_link_guard (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .req_i(lk_req_i),
        .clk_active_i(link_active_s),
        .no_abort_i(misc_function_config[OHCIMC_NOABORT_BIT]),
        .core_ack_i(lk_core_ack_i),
        .core_rdata_i(lk_core_rdata_i),
        .core_req_o(lk_core_req_o),
        .done_o(lk_done_o),
        .abort_o(lk_abort_o),
        .rdata_o(lk_rdata_o)
    );

endmodule
`default_nettype wire

// file: tb/ohcimc_regs_asserts.sv
// Purpose: Port checker for ohcimc_regs
// Assumes: One clock domain, async active-low reset
// Notes: Attached to every ohcimc_regs by bind
`timescale 1ns/1ps
`default_nettype none
module ohcimc_regs_chk
    import ohcimc_pkg::*;
#(
    parameter int DATA_W = 32
)
(
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic cfg_req_i,
    input wire logic cfg_we_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic cfg_ack_o,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic enhancement_enable_bit_i,
    input wire logic link_clk_need_i,
    input wire logic pci_clk_need_i,
    input wire logic lk_core_ack_i,
    input wire logic lk_done_o,
    input wire logic lk_abort_o,
    input wire logic [DATA_W-1:0] lk_rdata_o,
    input wire logic [2:0] pm_version_o,
    input wire logic link_clk_run_o,
    input wire logic pci_clk_run_o,
    input wire logic [31:0] lec_effective_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    AST_CFG_ACK: assert property (cfg_req_i |=> cfg_ack_o)
        else $error("config ack missing");
    AST_CFG_NOACK: assert property (!cfg_req_i |=> !cfg_ack_o)
        else $error("config ack without request");
    AST_PMV: assert property (cfg_ack_o && !$past(cfg_we_i)
        && $past(cfg_addr_i) == 8'hf0 |-> pm_version_o == (cfg_rdata_o[7] ? 3'h3 : 3'h2))
        else $error("version field disagrees with control bit");
    AST_RSVD: assert property (cfg_ack_o && !$past(cfg_we_i)
        && $past(cfg_addr_i) == 8'hf0 |-> (cfg_rdata_o & 32'hffff_ff60) == 32'h0)
        else $error("reserved misc bits read nonzero");
    AST_ABORT: assert property (lk_abort_o |-> lk_done_o && lk_rdata_o == '0)
        else $error("abort without done or with data");
    AST_FILL: assert property (lk_done_o && !lk_abort_o
        && !$past(lk_core_ack_i) |-> lk_rdata_o == {DATA_W{1'b1}})
        else $error("stopped link answer not all ones");
    AST_PCI_RUN: assert property ($past(pci_clk_need_i) |-> pci_clk_run_o)
        else $error("pci clock gated while needed");
    AST_LINK_RUN: assert property (link_clk_need_i [*4] |=> link_clk_run_o)
        else $error("link clock gated while needed");
    AST_LEC_OFF: assert property (!enhancement_enable_bit_i |=> lec_effective_o == 32'h0)
        else $error("enhancement active while disabled");
endmodule
bind ohcimc_regs ohcimc_regs_chk #(.DATA_W(DATA_W)) i_ohcimc_regs_chk (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .cfg_req_i(cfg_req_i),
    .cfg_we_i(cfg_we_i), .cfg_addr_i(cfg_addr_i), .cfg_ack_o(cfg_ack_o),
    .cfg_rdata_o(cfg_rdata_o), .enhancement_enable_bit_i(enhancement_enable_bit_i),
    .link_clk_need_i(link_clk_need_i), .pci_clk_need_i(pci_clk_need_i),
    .lk_core_ack_i(lk_core_ack_i), .lk_done_o(lk_done_o), .lk_abort_o(lk_abort_o),
    .lk_rdata_o(lk_rdata_o), .pm_version_o(pm_version_o), .link_clk_run_o(link_clk_run_o),
    .pci_clk_run_o(pci_clk_run_o), .lec_effective_o(lec_effective_o));
`default_nettype wire

// file: tb/ohcimc_regs_tb.sv
// Purpose: Self-checking bench for ohcimc_regs
// Assumes: 40 MHz clock, inputs driven 2 ns after rising edge
// Notes: Link core answered by the bench one cycle after forward
`timescale 1ns/1ps
`default_nettype none
module ohcimc_regs_tb
    import ohcimc_pkg::*;
();
    logic core_clk_i = 0;
    logic arst_n_i = 0;
    logic cfg_req_i = 0;
    logic cfg_we_i = 0;
    logic [7:0] cfg_addr_i = 0;
    logic [3:0] cfg_be_i = 0;
    logic [31:0] cfg_wdata_i = 0;
    logic eeprom_load_i = 0;
    logic [31:0] eeprom_lec_i = 0;
    logic en = 0;
    logic act = 0;
    logic lneed = 0;
    logic pneed = 0;
    logic lk_req_i = 0;
    logic lk_core_ack_i = 0;
    logic [31:0] lk_core_rdata_i = 0;
    logic cfg_ack_o, lk_core_req_o, lk_done_o, lk_abort_o, link_clk_run_o, pci_clk_run_o;
    logic [31:0] cfg_rdata_o, lk_rdata_o, lec_effective_o, rd;
    logic [2:0] pm_version_o;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;

    ohcimc_regs #(.DATA_W(32)) i_ohcimc_regs (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .cfg_req_i(cfg_req_i),
        .cfg_we_i(cfg_we_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i),
        .cfg_wdata_i(cfg_wdata_i), .cfg_ack_o(cfg_ack_o), .cfg_rdata_o(cfg_rdata_o),
        .eeprom_load_i(eeprom_load_i), .eeprom_lec_i(eeprom_lec_i),
        .enhancement_enable_bit_i(en), .link_clk_active_i(act), .link_clk_need_i(lneed),
        .pci_clk_need_i(pneed), .lk_req_i(lk_req_i), .lk_core_ack_i(lk_core_ack_i),
        .lk_core_rdata_i(lk_core_rdata_i), .lk_core_req_o(lk_core_req_o),
        .lk_done_o(lk_done_o), .lk_abort_o(lk_abort_o), .lk_rdata_o(lk_rdata_o),
        .pm_version_o(pm_version_o), .link_clk_run_o(link_clk_run_o),
        .pci_clk_run_o(pci_clk_run_o), .lec_effective_o(lec_effective_o));

    task automatic final_report();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk_i);
        #2;
    endtask

    task automatic cfg(input logic we, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] d);
        cfg_req_i = 1;
        cfg_we_i = we;
        cfg_addr_i = a;
        cfg_be_i = be;
        cfg_wdata_i = d;
        @(posedge core_clk_i);
        #2;
        // Ack and read data launched by the taking edge
        chk(cfg_ack_o, 1);
        rd = cfg_rdata_o;
        cfg_req_i = 0;
        @(posedge core_clk_i);
        #2;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        cfg(0, a, 4'h0, 32'h0);
        chk(rd, e);
    endtask

    // Link access, core acked one cycle after forward
    task automatic lk(input logic ab, input logic [31:0] d);
        int i;
        lk_req_i = 1;
        step(1);
        lk_req_i = 0;
        chk(lk_core_req_o, act);
        for (i = 0; i < 8 && lk_done_o !== 1'b1; i++)
        begin
            lk_core_ack_i = lk_core_req_o;
            @(posedge core_clk_i);
            #2;
        end
        lk_core_ack_i = 0;
        chk(lk_done_o, 1);
        chk(lk_abort_o, ab);
        chk(lk_rdata_o, d);
    endtask

    initial
    begin
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_errors++;
            final_report();
        end
    end

    initial
    begin
        step(20);
        arst_n_i = 1;
        rdchk(8'hf0, 32'h0000_0090);
        rdchk(8'hf4, 32'h0000_4000);
        chk(pm_version_o, 3'h3);
        chk({link_clk_run_o, pci_clk_run_o}, 2'b00);
        $display("test reset done");
        cfg(1, 8'hf0, 4'hf, 32'hffff_ffff);
        rdchk(8'hf0, 32'h0000_009f);
        chk({link_clk_run_o, pci_clk_run_o}, 2'b11);
        cfg(1, 8'hf0, 4'h0, 32'h0);
        rdchk(8'hf0, 32'h0000_009f);
        cfg(1, 8'hf0, 4'h1, 32'h0);
        rdchk(8'hf0, 32'h0);
        chk(pm_version_o, 3'h2);
        chk({link_clk_run_o, pci_clk_run_o}, 2'b00);
        pneed = 1;
        step(2);
        chk(pci_clk_run_o, 1);
        pneed = 0;
        lneed = 1;
        step(5);
        chk(link_clk_run_o, 1);
        lneed = 0;
        cfg(1, 8'hf0, 4'h1, 32'h0000_0009);
        rdchk(8'hf0, 32'h0000_0009);
        step(4);
        chk({link_clk_run_o, pci_clk_run_o}, 2'b00);
        $display("test misc done");
        lk(1, 32'h0);
        cfg(1, 8'hf0, 4'h1, 32'h0000_0010);
        lk(0, 32'hffff_ffff);
        act = 1;
        step(4);
        lk_core_rdata_i = 32'h1234_abcd;
        lk(0, 32'h1234_abcd);
        $display("test link done");
        cfg(1, 8'hf4, 4'hf, 32'hffff_ffff);
        rdchk(8'hf4, 32'h0000_f000);
        chk(lec_effective_o, 32'h0);
        en = 1;
        step(2);
        chk(lec_effective_o, 32'h0000_f000);
        eeprom_lec_i = 32'h0000_5a5a;
        eeprom_load_i = 1;
        step(1);
        eeprom_load_i = 0;
        rdchk(8'hf4, 32'h0000_5000);
        cfg(1, 8'h10, 4'hf, 32'hffff_ffff);
        rdchk(8'h10, 32'h0);
        $display("test enhancement done");
        arst_n_i = 0;
        step(2);
        arst_n_i = 1;
        rdchk(8'hf0, 32'h0000_0090);
        rdchk(8'hf4, 32'h0000_4000);
        $display("test second reset done");
        final_report();
    end
endmodule
`default_nettype wire
